// >>> hub_reset_config_sequencer.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`include "hub_consts.svh"

// Overview of operation
// - hold 8-bit controller current, 2 mA units
// - hold 8-bit port power delay, 2 ms units
// - undefined register reads return zero
// - undefined register writes ignored, no error
// - strap mode uses defaults for unstrapped settings
// - sample indicator pins after reset release
// - indicator polarity opposite to strap level
// - reset removes port power, transceivers off
// - reset restores defaults, indicators off
// - operational within 500 us of release
// - then start eeprom load when selected
// - eeprom load finishes within 99.5 ms
// - strap mode outputs inactive within 1.5 us
// - attach within 100 ms of configuration
// - host requests complete within 5 ms
// - bus reset clears address, config, power
module hub_reset_config_sequencer #(
	parameter int RECOVER_CYC  = `HUB_RECOVER_CYC,
	parameter int EE_CYC       = `HUB_EE_CYC,
	parameter int PON_UNIT_CYC = `HUB_PON_UNIT_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  cfg_sel,
	input  wire logic [1:0]  gr_strap,
	input  wire logic [1:0]  led_req,
	output logic [1:0]       led_out,
	output logic [1:0]       led_oe,
	output logic             ee_start,
	input  wire logic        ee_wr_valid,
	input  wire logic [7:0]  ee_wr_addr,
	input  wire logic [7:0]  ee_wr_data,
	input  wire logic        ee_done,
	output logic             phy_enable,
	output logic             usb_attach,
	input  wire logic        usb_bus_reset,
	output logic             tt_clear,
	input  wire logic        host_req,
	output logic             host_req_done,
	input  wire logic        host_set_addr,
	input  wire logic [6:0]  host_addr,
	input  wire logic        host_set_config,
	input  wire logic        host_port_power_on,
	input  wire logic        host_port_power_off,
	output logic             downstream_port_power_enable,
	output logic             port_power_good,
	output logic [6:0]       usb_dev_addr,
	output logic             hub_configured
);

	hub_pkg::seq_s s_q;
	hub_pkg::seq_s s_d;
	logic          apb_wr;
	logic [9:0]    apb_idx;
	logic          apb_aligned;

	assign apb_idx     = paddr[11:2];
	assign apb_aligned = (paddr[1:0] == 2'h0);
	assign apb_wr      = psel & penable & s_q.pready & pwrite;

	always_comb begin
		s_d          = s_q;
		s_d.ee_start = 1'b0;
		s_d.tt_clear = 1'b0;
		s_d.req_done = 1'b0;
		s_d.pready   = 1'b0;
		s_d.prdata   = 32'h0000_0000;
		case (s_q.state)
			hub_pkg::ST_SAMPLE: begin
				case (cfg_sel)
					2'b00: s_d.src = hub_pkg::SRC_DEFAULT;
					2'b01: s_d.src = hub_pkg::SRC_STRAP;
					default: s_d.src = hub_pkg::SRC_EEPROM;
				endcase
				s_d.strap = gr_strap;
				s_d.led_oe  = 2'b11;
				s_d.led_out = gr_strap;
				if (cfg_sel[1] == 1'b0) begin
					s_d.cur = `HUB_CUR_DEF;
				end
				s_d.cnt   = 21'h0;
				s_d.state = hub_pkg::ST_RECOVER;
			end
			hub_pkg::ST_RECOVER: begin
				s_d.cnt = s_q.cnt + 21'h1;
				if (s_q.cnt == 21'(RECOVER_CYC - 2)) begin
					s_d.cnt = 21'h0;
					if (s_q.src == hub_pkg::SRC_EEPROM) begin
						s_d.ee_start = 1'b1;
						s_d.state    = hub_pkg::ST_EELOAD;
					end else begin
						s_d.phy_en = 1'b1;
						s_d.attach = 1'b1;
						s_d.state  = hub_pkg::ST_RUN;
					end
				end
			end
			hub_pkg::ST_EELOAD: begin
				s_d.cnt = s_q.cnt + 21'h1;
				if (ee_wr_valid) begin
					if ({2'h0, ee_wr_addr} == `HUB_IDX_CUR) begin
						s_d.cur = ee_wr_data;
					end
					if ({2'h0, ee_wr_addr} == `HUB_IDX_PON) begin
						s_d.pon = ee_wr_data;
					end
				end
				if (ee_done || s_q.cnt == 21'(EE_CYC - 1)) begin
					s_d.cnt = 21'h0;
					s_d.phy_en = 1'b1;
					s_d.attach = 1'b1;
					s_d.state  = hub_pkg::ST_RUN;
				end
			end
			hub_pkg::ST_RUN: begin
				s_d.req_done = host_req;
				if (host_set_addr) begin
					s_d.dev_addr = host_addr;
				end
				if (host_set_config) begin
					s_d.configured = 1'b1;
				end
				if (host_port_power_on) begin
					s_d.port_pwr  = 1'b1;
					s_d.port_good = 1'b0;
					s_d.pon_cnt   = s_q.pon;
					s_d.pon_div   = 16'h0000;
				end else if (s_q.port_pwr && !s_q.port_good) begin
					if (s_q.pon_cnt == 8'h00) begin
						s_d.port_good = 1'b1;
					end else if (s_q.pon_div == 16'(PON_UNIT_CYC - 1)) begin
						s_d.pon_div = 16'h0000;
						s_d.pon_cnt = s_q.pon_cnt - 8'h01;
					end else begin
						s_d.pon_div = s_q.pon_div + 16'h0001;
					end
				end
				if (host_port_power_off) begin
					s_d.port_pwr  = 1'b0;
					s_d.port_good = 1'b0;
				end
				if (usb_bus_reset) begin
					s_d.dev_addr   = 7'h00;
					s_d.configured = 1'b0;
					s_d.port_pwr   = 1'b0;
					s_d.port_good  = 1'b0;
					s_d.tt_clear   = 1'b1;
				end
			end
			default: begin
				s_d.state = hub_pkg::ST_SAMPLE;
			end
		endcase
		if (s_q.state != hub_pkg::ST_SAMPLE) begin
			s_d.led_out = (led_req & {2{s_q.state == hub_pkg::ST_RUN}}) ^ s_q.strap;
		end
		// answer in the first access cycle
		if (psel && !penable) begin
			s_d.pready = 1'b1;
			if (!pwrite && apb_aligned) begin
				case (apb_idx)
					`HUB_IDX_CUR: s_d.prdata = {24'h00_0000, s_q.cur};
					`HUB_IDX_PON: s_d.prdata = {24'h00_0000, s_q.pon};
					`HUB_IDX_STAT: s_d.prdata = {24'h00_0000, s_q.port_good, s_q.attach,
						s_q.configured, 2'b00, s_q.src};
					default: s_d.prdata = 32'h0000_0000;
				endcase
			end
		end
		if (apb_wr && apb_aligned && apb_idx == `HUB_IDX_CUR) begin
			s_d.cur = pwdata[7:0];
		end
		if (apb_wr && apb_aligned && apb_idx == `HUB_IDX_PON) begin
			s_d.pon = pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q       <= '0;
			s_q.state <= hub_pkg::ST_SAMPLE;
			s_q.src   <= hub_pkg::SRC_DEFAULT;
			s_q.cur   <= `HUB_CUR_RST;
			s_q.pon   <= `HUB_PON_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata                       = s_q.prdata;
	assign pready                       = s_q.pready;
	assign pslverr                      = 1'b0;
	assign led_out                      = s_q.led_out;
	assign led_oe                       = s_q.led_oe;
	assign ee_start                     = s_q.ee_start;
	assign phy_enable                   = s_q.phy_en;
	assign usb_attach                   = s_q.attach;
	assign tt_clear                     = s_q.tt_clear;
	assign host_req_done                = s_q.req_done;
	assign downstream_port_power_enable = s_q.port_pwr;
	assign port_power_good              = s_q.port_good;
	assign usb_dev_addr                 = s_q.dev_addr;
	assign hub_configured               = s_q.configured;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic undef_idx;
	assign undef_idx = !apb_aligned || (apb_idx != `HUB_IDX_CUR && apb_idx != `HUB_IDX_PON
		&& apb_idx != `HUB_IDX_STAT);

	property p_rd_undef;
		psel && !penable && !pwrite && undef_idx |=> pready && prdata == 32'h0000_0000;
	endproperty
	a_rd_undef: assert property (p_rd_undef) else $error("undefined read not zero");

	property p_wr_undef;
		apb_wr && undef_idx && s_q.state == hub_pkg::ST_RUN
			|=> $stable(s_q.cur) && $stable(s_q.pon);
	endproperty
	a_wr_undef: assert property (p_wr_undef) else $error("undefined write changed state");

	property p_wr_cur;
		apb_wr && apb_aligned && apb_idx == `HUB_IDX_CUR |=> s_q.cur == $past(pwdata[7:0]);
	endproperty
	a_wr_cur: assert property (p_wr_cur) else $error("current register not written");

	property p_recover;
		s_q.state == hub_pkg::ST_RECOVER |-> s_q.cnt < 21'(RECOVER_CYC);
	endproperty
	a_recover: assert property (p_recover) else $error("recovery overran");

	property p_ee_go;
		s_q.state == hub_pkg::ST_RECOVER && s_q.cnt == 21'(RECOVER_CYC - 2)
			&& s_q.src == hub_pkg::SRC_EEPROM |=> ee_start && s_q.state == hub_pkg::ST_EELOAD;
	endproperty
	a_ee_go: assert property (p_ee_go) else $error("eeprom load not started");

	property p_ee_limit;
		s_q.state == hub_pkg::ST_EELOAD |-> s_q.cnt < 21'(EE_CYC);
	endproperty
	a_ee_limit: assert property (p_ee_limit) else $error("eeprom load overran");

	property p_strap_drive;
		s_q.state == hub_pkg::ST_SAMPLE |=> led_oe == 2'b11 && led_out == s_q.strap;
	endproperty
	a_strap_drive: assert property (p_strap_drive) else $error("outputs not inactive");

	property p_led_pol;
		s_q.state == hub_pkg::ST_RUN ##1 s_q.state == hub_pkg::ST_RUN
			|-> led_out == ($past(led_req) ^ s_q.strap);
	endproperty
	a_led_pol: assert property (p_led_pol) else $error("indicator polarity wrong");

	property p_attach;
		$rose(s_q.state == hub_pkg::ST_RUN) |-> usb_attach && phy_enable;
	endproperty
	a_attach: assert property (p_attach) else $error("attach missing");

	property p_req;
		s_q.state == hub_pkg::ST_RUN && host_req |=> host_req_done;
	endproperty
	a_req: assert property (p_req) else $error("request not completed");

	property p_src;
		s_q.state != hub_pkg::ST_SAMPLE && $past(s_q.state) != hub_pkg::ST_SAMPLE
			|-> $onehot(s_q.src) && $stable(s_q.src);
	endproperty
	a_src: assert property (p_src) else $error("source not unique");

	property p_bus_reset;
		s_q.state == hub_pkg::ST_RUN && usb_bus_reset |=> usb_dev_addr == 7'h00
			&& !hub_configured && !downstream_port_power_enable && tt_clear;
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("bus reset incomplete");

	property p_defaults;
		s_q.state == hub_pkg::ST_SAMPLE && cfg_sel == 2'b01 |=> s_q.cur == `HUB_CUR_DEF;
	endproperty
	a_defaults: assert property (p_defaults) else $error("defaults not loaded");

	property p_good;
		port_power_good |-> downstream_port_power_enable;
	endproperty
	a_good: assert property (p_good) else $error("power good without power");

	c_ee_run: cover property (s_q.state == hub_pkg::ST_EELOAD ##1 s_q.state == hub_pkg::ST_RUN);
	c_good: cover property ($rose(port_power_good));
	c_bus_reset: cover property (s_q.state == hub_pkg::ST_RUN && usb_bus_reset);
	c_rd: cover property (psel && penable && pready && !pwrite && prdata != 32'h0000_0000);

endmodule

// >>> hub_consts.svh
`ifndef HUB_CONSTS_SVH
`define HUB_CONSTS_SVH

// register indices, byte address is four times the index
`define HUB_IDX_CUR 10'h00F
`define HUB_IDX_PON 10'h010
`define HUB_IDX_STAT 10'h011

// reset and default values
`define HUB_CUR_RST 8'h00
`define HUB_PON_RST 8'h00
`define HUB_CUR_DEF 8'h32

// status register field positions
`define HUB_STAT_SRC_LSB 0
`define HUB_STAT_CFGD_BIT 5
`define HUB_STAT_ATT_BIT 6
`define HUB_STAT_PGOOD_BIT 7

// times in ns
`define HUB_CLK_NS 50
`define HUB_STRAP_NS 1500
`define HUB_RECOVER_NS 500000
`define HUB_EE_NS 99500000
`define HUB_PON_UNIT_NS 2000000

// cycle counts, longest times rounded down
`define HUB_STRAP_CYC (`HUB_STRAP_NS / `HUB_CLK_NS)
`define HUB_RECOVER_CYC (`HUB_RECOVER_NS / `HUB_CLK_NS)
`define HUB_EE_CYC (`HUB_EE_NS / `HUB_CLK_NS)
`define HUB_PON_UNIT_CYC (`HUB_PON_UNIT_NS / `HUB_CLK_NS)

`endif

// >>> hub_pkg.sv
package hub_pkg;

	typedef enum logic [3:0] {
		ST_SAMPLE  = 4'b0001,
		ST_RECOVER = 4'b0010,
		ST_EELOAD  = 4'b0100,
		ST_RUN     = 4'b1000
	} seq_state_e;

	typedef enum logic [2:0] {
		SRC_DEFAULT = 3'b001,
		SRC_STRAP   = 3'b010,
		SRC_EEPROM  = 3'b100
	} cfg_src_e;

	typedef struct packed {
		seq_state_e  state;
		cfg_src_e    src;
		logic [20:0] cnt;
		logic [7:0]  cur;
		logic [7:0]  pon;
		logic [1:0]  strap;
		logic [1:0]  led_oe;
		logic [1:0]  led_out;
		logic        phy_en;
		logic        attach;
		logic        configured;
		logic [6:0]  dev_addr;
		logic        port_pwr;
		logic        port_good;
		logic [15:0] pon_div;
		logic [7:0]  pon_cnt;
		logic        ee_start;
		logic        tt_clear;
		logic        req_done;
		logic [31:0] prdata;
		logic        pready;
	} seq_s;

endpackage

// >>> hub_ee_model.sv
`timescale 1ns/1ns
module hub_ee_model #(
	parameter logic [7:0] LOAD_VAL = 8'h40,
	parameter int         DLY      = 5
) (
	input  wire logic  pclk,
	input  wire logic  ee_start,
	output logic       ee_wr_valid,
	output logic [7:0] ee_wr_addr,
	output logic [7:0] ee_wr_data,
	output logic       ee_done
);
	initial begin
		ee_wr_valid = 1'b0;
		ee_wr_addr = 8'h00;
		ee_wr_data = 8'h00;
		ee_done = 1'b0;
	end
	always @(posedge pclk) begin
		if (ee_start === 1'b1) begin
			repeat (DLY) @(posedge pclk);
			ee_wr_valid <= 1'b1;
			ee_wr_addr <= 8'h0F;
			ee_wr_data <= LOAD_VAL;
			@(posedge pclk);
			ee_wr_valid <= 1'b0;
			ee_done <= 1'b1;
			ee_wr_addr <= 8'hF0;
			ee_wr_data <= ~LOAD_VAL;
			@(posedge pclk);
			ee_done <= 1'b0;
		end
	end
endmodule

// >>> test_hub_reset_config_sequencer.sv
`timescale 1ns/1ns
module test_hub_reset_config_sequencer;
	localparam int REC = 20;
	localparam int PU  = 8;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0]  cfg_sel = 2'b01, gr_strap = 2'b10, led_req = 2'b00, led_out, led_oe;
	logic        ee_start, ee_wr_valid, ee_done, phy_enable, usb_attach, tt_clear;
	logic [7:0]  ee_wr_addr, ee_wr_data;
	logic        usb_bus_reset = 0, host_req = 0, host_req_done, host_set_addr = 0;
	logic        host_set_config = 0, host_port_power_on = 0, host_port_power_off = 0;
	logic        downstream_port_power_enable, port_power_good, hub_configured;
	logic [6:0]  host_addr = 7'h05, usb_dev_addr;
	int          fails = 0, checked = 0, cyc = 0, n;
	logic        err;

	hub_reset_config_sequencer #(.RECOVER_CYC(REC), .EE_CYC(200), .PON_UNIT_CYC(PU))
	u_hub_reset_config_sequencer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cfg_sel, .gr_strap, .led_req, .led_out,
		.led_oe, .ee_start, .ee_wr_valid, .ee_wr_addr, .ee_wr_data, .ee_done, .phy_enable,
		.usb_attach, .usb_bus_reset, .tt_clear, .host_req, .host_req_done, .host_set_addr,
		.host_addr, .host_set_config, .host_port_power_on, .host_port_power_off,
		.downstream_port_power_enable, .port_power_good, .usb_dev_addr, .hub_configured);
	hub_ee_model #(.LOAD_VAL(8'h40), .DLY(5)) u_hub_ee_model (.pclk, .ee_start,
		.ee_wr_valid, .ee_wr_addr, .ee_wr_data, .ee_done);

	always #25 pclk = ~pclk;

	task automatic give_verdict();
		if (fails == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return host_req_done;
			1: return port_power_good;
			2: return tt_clear;
			default: return usb_attach;
		endcase
	endfunction

	task automatic wait_for(input int s, input int lim);
		n = 0;
		while (pick(s) !== 1'b1 && n < lim) begin
			@(negedge pclk);
			n++;
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask

	task automatic boot(input logic [1:0] sel, input int lim);
		@(posedge pclk);
		presetn <= 1'b0;
		cfg_sel <= sel;
		repeat (20) @(posedge pclk);
		chk("reset_idle", {28'h0, led_oe, downstream_port_power_enable, usb_attach}, 32'h0);
		chk("phy_off", {31'h0, phy_enable}, 32'h0);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk("led_oe", {30'h0, led_oe}, 32'h3);
		chk("led_idle", {30'h0, led_out}, {30'h0, gr_strap});
		wait_for(3, lim);
		chk("attach", {30'h0, phy_enable, usb_attach}, 32'h3);
	endtask

	initial begin
		boot(2'b01, 30);
		rd_chk("cur_strap", 12'h03C, 32'h32);
		rd_chk("pon_rst", 12'h040, 32'h0);
		rd_chk("stat_strap", 12'h044, 32'h42);
		rd_chk("undef_rd", 12'h048, 32'h0);
		rd_chk("unalign_rd", 12'h03D, 32'h0);
		apb(1'b1, 12'h048, 32'h000000A5);
		chk("undef_err", {31'h0, err}, 32'h0);
		rd_chk("undef_wr", 12'h03C, 32'h32);
		apb(1'b1, 12'h03C, 32'h00000019);
		rd_chk("cur_wr", 12'h03C, 32'h19);
		apb(1'b1, 12'h040, 32'h00000002);
		rd_chk("pon_wr", 12'h040, 32'h2);
		@(posedge pclk);
		led_req <= 2'b01;
		host_req <= 1'b1;
		@(posedge pclk);
		host_req <= 1'b0;
		wait_for(0, 3);
		chk("req_done", {31'h0, pick(0)}, 32'h1);
		@(negedge pclk);
		chk("led_run", {30'h0, led_out}, 32'h3);
		@(posedge pclk);
		host_port_power_on <= 1'b1;
		@(posedge pclk);
		host_port_power_on <= 1'b0;
		@(negedge pclk);
		chk("pwr_en", {31'h0, downstream_port_power_enable}, 32'h1);
		wait_for(1, 40);
		chk("pgood_time", {31'h0, n >= 2 * PU && n <= 2 * PU + 6}, 32'h1);
		@(posedge pclk);
		host_set_addr <= 1'b1;
		host_set_config <= 1'b1;
		@(posedge pclk);
		host_set_addr <= 1'b0;
		host_set_config <= 1'b0;
		@(negedge pclk);
		chk("addr_cfg", {24'h0, usb_dev_addr, hub_configured}, 32'h0B);
		repeat (10) @(posedge pclk);
		usb_bus_reset <= 1'b1;
		@(posedge pclk);
		usb_bus_reset <= 1'b0;
		wait_for(2, 3);
		chk("tt_clear", {31'h0, pick(2)}, 32'h1);
		@(negedge pclk);
		chk("bus_rst", {22'h0, usb_dev_addr, hub_configured, downstream_port_power_enable,
			port_power_good}, 32'h0);
		boot(2'b10, 60);
		rd_chk("cur_ee", 12'h03C, 32'h40);
		rd_chk("stat_ee", 12'h044, 32'h44);
		rd_chk("pon_clr", 12'h040, 32'h0);
		boot(2'b00, 30);
		rd_chk("stat_def", 12'h044, 32'h41);
		rd_chk("cur_def", 12'h03C, 32'h32);
		give_verdict();
	end
endmodule
